// >>> include/bps_pkg.sv
package bps_pkg;

    // Configuration space byte offsets
    localparam logic [7:0] BPS_CMD_OFF = 8'h04;
    localparam logic [7:0] BPS_STATUS_OFF = 8'h06;
    localparam logic [7:0] BPS_REV_OFF = 8'h08;

    // Command word field positions and reset value
    localparam int BPS_CMD_PERR_RESP_BIT = 6;
    localparam int BPS_CMD_SERR_EN_BIT = 8;
    localparam logic [15:0] BPS_CMD_RESET = 16'h0000;

    // Status word field positions
    localparam int BPS_ST_DET_PERR_BIT = 15;
    localparam int BPS_ST_SIG_SERR_BIT = 14;
    localparam int BPS_ST_RCV_MABORT_BIT = 13;
    localparam int BPS_ST_RCV_TABORT_BIT = 12;
    localparam int BPS_ST_SIG_TABORT_BIT = 11;
    localparam int BPS_ST_DEVSEL_LO_BIT = 9;
    localparam int BPS_ST_DATA_PERR_BIT = 8;
    localparam int BPS_ST_FAST_B2B_BIT = 7;
    localparam int BPS_ST_USER_FEATURE_BIT = 6;
    localparam int BPS_ST_MHZ66_BIT = 5;
    localparam int BPS_ST_CAP_LIST_BIT = 4;

    // Hardwired status content
    localparam logic [1:0] BPS_ST_DEVSEL_MEDIUM = 2'h1;
    localparam logic BPS_ST_FAST_B2B_VAL = 1'b0;
    localparam logic BPS_ST_USER_FEATURE_VAL = 1'b0;
    localparam logic BPS_ST_MHZ66_VAL = 1'b0;
    localparam logic BPS_ST_CAP_LIST_VAL = 1'b1;
    localparam logic [3:0] BPS_ST_RESERVED_VAL = 4'h0;
    localparam logic [15:0] BPS_STATUS_RESET = 16'h0210;

    // Revision byte; value is arbitrary
    localparam logic [7:0] BPS_REV_DEFAULT = 8'h5A;

    // Pin synchroniser depth
    localparam int BPS_SYNC_STAGES = 3;

    // Configuration access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } bps_cfg_req_s;

    // Configuration access answer
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } bps_cfg_rsp_s;

    // Same-clock events from the bridge core
    typedef struct packed {
        logic parity_detected;
        logic serr_request;
        logic master_abort_rcvd;
        logic target_abort_rcvd;
        logic target_abort_sent;
        logic bus_master;
    } bps_evt_s;

endpackage

// >>> src/bps_pin_sync.sv
`timescale 1ns/1ps

module bps_pin_sync
    import bps_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_pin,
    output logic o_level
);

    typedef struct packed {
        logic [BPS_SYNC_STAGES-1:0] ff;
        logic level;
    } bps_sync_s;

    bps_sync_s state_r;
    bps_sync_s state_nxt;

    // Stage 0 feeds only stage 1; the filter looks at stages 1 and 2
    always_comb begin
        state_nxt = state_r;
        state_nxt.ff = {state_r.ff[BPS_SYNC_STAGES-2:0], i_pin};
        if (state_r.ff[1] == state_r.ff[2]) begin
            state_nxt.level = state_r.ff[2];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= '{ff: {BPS_SYNC_STAGES{RESET_LEVEL}}, level: RESET_LEVEL};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_level = state_r.level;

endmodule // bps_pin_sync

// >>> src/bps_status_regs.sv
`timescale 1ns/1ps

// Overview of operation
// - Writing one clears error flag; zero keeps.
// - Status word at 06h, resets to 0210h.
// - Bit 15 set on any detected parity error.
// - Bit 14 set on system error when enabled.
// - Bit 13 set on received master abort.
// - Bit 12 set on received target abort.
// - Bit 11 set when signalling target abort.
// - Bits 10-9 read constant 01b, medium timing.
// - Bit 8 needs parity line, mastership, response enable.
// - Bit 7 reads zero, no fast back-to-back.
// - Bit 6 reads zero, no user features.
// - Bit 5 reads zero, no 66 MHz.
// - Bit 4 reads one, capabilities list present.
// - Bits 3-0 reserved, read zero.
// - Revision byte at 08h, fixed read-only.
// - Command bit 8 enables system error driver.
// - Command bit 6 enables parity error response.
module bps_status_regs
    import bps_pkg::*;
#(
    parameter logic [7:0] REVISION = BPS_REV_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire bps_cfg_req_s i_cfg_req,
    output bps_cfg_rsp_s o_cfg_rsp,
    input wire bps_evt_s i_evt,
    input wire logic i_primary_parity_error_line_n,
    output logic o_serr_pin_out,
    output logic o_serr_pin_oe_n,
    output logic o_serr_enable,
    output logic o_parity_resp_enable,
    output logic [15:0] o_status
);

    typedef struct packed {
        logic serr_en;
        logic perr_resp;
        logic det_perr;
        logic sig_serr;
        logic rcv_mabort;
        logic rcv_tabort;
        logic sig_tabort;
        logic data_perr;
        logic serr_drive;
        logic ack;
        logic [31:0] rdata;
    } bps_state_s;

    bps_state_s state_r;
    bps_state_s state_nxt;

    logic perr_line_n;
    logic perr_asserted;
    logic cmd_hit;
    logic rev_hit;
    logic [15:0] status_word;
    logic [15:0] cmd_word;
    logic [15:0] clr_mask;
    logic wr_status;

    // Decode of the dword that holds a given byte offset
    function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] off);
        dword_hit = (addr[7:2] == off[7:2]);
    endfunction

    // Status word assembly from flags plus hardwired fields
    function automatic logic [15:0] build_status(input bps_state_s s);
        logic [15:0] w;
        w = 16'h0000;
        w[BPS_ST_DET_PERR_BIT] = s.det_perr;
        w[BPS_ST_SIG_SERR_BIT] = s.sig_serr;
        w[BPS_ST_RCV_MABORT_BIT] = s.rcv_mabort;
        w[BPS_ST_RCV_TABORT_BIT] = s.rcv_tabort;
        w[BPS_ST_SIG_TABORT_BIT] = s.sig_tabort;
        w[BPS_ST_DEVSEL_LO_BIT+1:BPS_ST_DEVSEL_LO_BIT] = BPS_ST_DEVSEL_MEDIUM;
        w[BPS_ST_DATA_PERR_BIT] = s.data_perr;
        w[BPS_ST_FAST_B2B_BIT] = BPS_ST_FAST_B2B_VAL;
        w[BPS_ST_USER_FEATURE_BIT] = BPS_ST_USER_FEATURE_VAL;
        w[BPS_ST_MHZ66_BIT] = BPS_ST_MHZ66_VAL;
        w[BPS_ST_CAP_LIST_BIT] = BPS_ST_CAP_LIST_VAL;
        w[3:0] = BPS_ST_RESERVED_VAL;
        build_status = w;
    endfunction

    // Parity line is an asynchronous pin, so it is filtered before use
    bps_pin_sync #(
        .RESET_LEVEL(1'b1)
    ) u_perr_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_primary_parity_error_line_n),
        .o_level(perr_line_n)
    );

    assign perr_asserted = ~perr_line_n;
    assign cmd_hit = dword_hit(i_cfg_req.addr, BPS_CMD_OFF);
    assign rev_hit = dword_hit(i_cfg_req.addr, BPS_REV_OFF);
    assign status_word = build_status(state_r);

    always_comb begin
        cmd_word = BPS_CMD_RESET;
        cmd_word[BPS_CMD_PERR_RESP_BIT] = state_r.perr_resp;
        cmd_word[BPS_CMD_SERR_EN_BIT] = state_r.serr_en;
    end

    // Only the upper half of the command dword holds the status word
    assign wr_status = i_cfg_req.wr & cmd_hit;

    always_comb begin
        clr_mask = 16'h0000;
        if (wr_status) begin
            if (i_cfg_req.be[2]) begin
                clr_mask[7:0] = i_cfg_req.wdata[23:16];
            end
            if (i_cfg_req.be[3]) begin
                clr_mask[15:8] = i_cfg_req.wdata[31:24];
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.ack = i_cfg_req.rd | i_cfg_req.wr;

        // Command enables, byte-lane gated
        if (wr_status && i_cfg_req.be[0]) begin
            state_nxt.perr_resp = i_cfg_req.wdata[BPS_CMD_PERR_RESP_BIT];
        end
        if (wr_status && i_cfg_req.be[1]) begin
            state_nxt.serr_en = i_cfg_req.wdata[BPS_CMD_SERR_EN_BIT];
        end

        // System error driven only while its driver is enabled
        state_nxt.serr_drive = i_evt.serr_request & state_r.serr_en;

        // Clear first, then set, so a same-cycle event survives
        state_nxt.det_perr = state_r.det_perr & ~clr_mask[BPS_ST_DET_PERR_BIT];
        state_nxt.sig_serr = state_r.sig_serr & ~clr_mask[BPS_ST_SIG_SERR_BIT];
        state_nxt.rcv_mabort = state_r.rcv_mabort & ~clr_mask[BPS_ST_RCV_MABORT_BIT];
        state_nxt.rcv_tabort = state_r.rcv_tabort & ~clr_mask[BPS_ST_RCV_TABORT_BIT];
        state_nxt.sig_tabort = state_r.sig_tabort & ~clr_mask[BPS_ST_SIG_TABORT_BIT];
        state_nxt.data_perr = state_r.data_perr & ~clr_mask[BPS_ST_DATA_PERR_BIT];

        if (i_evt.parity_detected) begin
            state_nxt.det_perr = 1'b1;
        end
        if (state_r.serr_drive) begin
            state_nxt.sig_serr = 1'b1;
        end
        if (i_evt.master_abort_rcvd) begin
            state_nxt.rcv_mabort = 1'b1;
        end
        if (i_evt.target_abort_rcvd) begin
            state_nxt.rcv_tabort = 1'b1;
        end
        if (i_evt.target_abort_sent) begin
            state_nxt.sig_tabort = 1'b1;
        end
        if (perr_asserted && i_evt.bus_master && state_r.perr_resp) begin
            state_nxt.data_perr = 1'b1;
        end

        // Read data; unmapped dwords and write cycles return zero
        state_nxt.rdata = 32'h0000_0000;
        if (i_cfg_req.rd) begin
            if (cmd_hit) begin
                state_nxt.rdata = {status_word, cmd_word};
            end else if (rev_hit) begin
                state_nxt.rdata = {24'h00_0000, REVISION};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_cfg_rsp = '{ack: state_r.ack, rdata: state_r.rdata};
    assign o_serr_pin_out = 1'b0;
    assign o_serr_pin_oe_n = ~state_r.serr_drive;
    assign o_serr_enable = state_r.serr_en;
    assign o_parity_resp_enable = state_r.perr_resp;
    assign o_status = status_word;

endmodule // bps_status_regs

// >>> verif/bps_status_monitor.sv
`timescale 1ns/1ps
module bps_status_monitor
    import bps_pkg::*;
#(
    parameter logic [7:0] REVISION = BPS_REV_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire bps_cfg_req_s i_cfg_req,
    input wire bps_cfg_rsp_s o_cfg_rsp,
    input wire bps_evt_s i_evt,
    input wire logic o_serr_pin_oe_n,
    input wire logic [15:0] o_status
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic st_rd;
    logic clr15;
    assign st_rd = i_cfg_req.rd && i_cfg_req.addr[7:2] == 6'h01;
    assign clr15 = i_cfg_req.wr && i_cfg_req.addr[7:2] == 6'h01 && i_cfg_req.be[3];
    chk_status_read: assert property (st_rd |=> o_cfg_rsp.ack &&
        (o_status != $past(o_status) || o_cfg_rsp.rdata[31:16] == o_status))
        else $error("status read wrong");
    chk_devsel_medium: assert property (o_status[10:9] == 2'h1)
        else $error("timing field not 01");
    chk_low_byte: assert property (o_status[7:0] == 8'h10)
        else $error("fixed low byte wrong");
    chk_parity_sets: assert property (i_evt.parity_detected |=> o_status[15])
        else $error("bit 15 not set");
    chk_mabort_sets: assert property (i_evt.master_abort_rcvd |=> o_status[13])
        else $error("bit 13 not set");
    chk_tabort_rcvd: assert property (i_evt.target_abort_rcvd |=> o_status[12])
        else $error("bit 12 not set");
    chk_tabort_sent: assert property (i_evt.target_abort_sent |=> o_status[11])
        else $error("bit 11 not set");
    chk_serr_gated: assert property ($rose(o_status[14]) |-> $past(!o_serr_pin_oe_n))
        else $error("bit 14 set without driving");
    chk_w1c_clear: assert property (clr15 && i_cfg_req.wdata[31] &&
        !i_evt.parity_detected |=> !o_status[15])
        else $error("bit 15 not cleared");
    chk_rev_read: assert property (i_cfg_req.rd && i_cfg_req.addr[7:2] == 6'h02
        |=> o_cfg_rsp.rdata == {24'h000000, REVISION})
        else $error("revision read wrong");
    cover property (clr15 && i_cfg_req.wdata[29] && i_evt.master_abort_rcvd);
    cover property ($rose(o_status[14]));
    cover property ($rose(o_status[8]));
endmodule // bps_status_monitor

bind bps_status_regs bps_status_monitor #(.REVISION(REVISION)) u_mon (.i_clk(i_clk),
    .i_reset(i_reset), .i_cfg_req(i_cfg_req), .o_cfg_rsp(o_cfg_rsp), .i_evt(i_evt),
    .o_serr_pin_oe_n(o_serr_pin_oe_n), .o_status(o_status));

// >>> verif/bps_host_model.sv
`timescale 1ns/1ps
module bps_host_model
    import bps_pkg::*;
(
    input wire logic i_clk,
    output bps_cfg_req_s o_cfg_req,
    input wire bps_cfg_rsp_s i_cfg_rsp
);
    initial o_cfg_req = '0;
    // Idle bus shows inverted leftovers so stale data never looks valid
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
            input logic [31:0] wd, output logic [31:0] rd, output logic ack);
        @(posedge i_clk);
        #1;
        o_cfg_req = '{rd: !wr, wr: wr, addr: a, be: be, wdata: wd};
        @(posedge i_clk);
        #1;
        o_cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~be, wdata: ~wd};
        // Registered answer stands for this cycle only, so take it now
        ack = i_cfg_rsp.ack;
        rd = i_cfg_rsp.rdata;
    endtask
endmodule // bps_host_model

// >>> verif/bridge_primary_status_regs_bench.sv
`timescale 1ns/1ps
module bridge_primary_status_regs_bench;
    import bps_pkg::*;
    logic i_clk, i_reset, pin_n, ack, oe_n, s_en, p_en;
    logic [15:0] st;
    logic [31:0] rd;
    bps_cfg_req_s req;
    bps_cfg_rsp_s rsp;
    bps_evt_s evt;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    bps_status_regs dut (.i_clk(i_clk), .i_reset(i_reset), .i_cfg_req(req), .o_cfg_rsp(rsp),
        .i_evt(evt), .i_primary_parity_error_line_n(pin_n), .o_serr_pin_out(),
        .o_serr_pin_oe_n(oe_n), .o_serr_enable(s_en), .o_parity_resp_enable(p_en),
        .o_status(st));
    bps_host_model host (.i_clk(i_clk), .o_cfg_req(req), .i_cfg_rsp(rsp));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
            input logic [31:0] wd);
        host.cfg(wr, a, be, wd, rd, ack);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic t_fixed;
        check("reset status", st, 32'h0210);
        acc(1'b0, BPS_STATUS_OFF, 4'hF, 32'h0);
        check("dword 04", {ack, rd}, {1'b1, 32'h0210_0000});
        acc(1'b1, BPS_CMD_OFF, 4'hF, 32'hFFFF_FFFF);
        check("status after ones", st, 32'h0210);
        check("enables", {s_en, p_en}, 2'h3);
        acc(1'b1, BPS_REV_OFF, 4'hF, 32'hFFFF_FFFF);
        acc(1'b0, BPS_REV_OFF, 4'hF, 32'h0);
        check("revision", rd, {24'h000000, BPS_REV_DEFAULT});
        acc(1'b1, BPS_CMD_OFF, 4'h3, 32'h0);
        check("enables off", {s_en, p_en}, 2'h0);
    endtask
    task automatic t_flags;
        int ev[4] = '{5, 3, 2, 1};
        int sb[4] = '{15, 13, 12, 11};
        for (int i = 0; i < 4; i++) begin
            evt[ev[i]] = 1'b1;
            step(1);
            evt = '0;
            check("flag set", st[sb[i]], 1'b1);
            acc(1'b1, BPS_CMD_OFF, 4'hC, 32'h0);
            check("flag kept", st[sb[i]], 1'b1);
            acc(1'b1, BPS_CMD_OFF, 4'hC, 32'h1 << (sb[i] + 16));
            check("flag cleared", st, 32'h0210);
        end
    endtask
    task automatic t_serr;
        evt.serr_request = 1'b1;
        step(4);
        check("serr off", {oe_n, st[14]}, 2'h2);
        acc(1'b1, BPS_CMD_OFF, 4'h3, 32'h100);
        step(3);
        check("serr on", {oe_n, st[14]}, 2'h1);
        evt = '0;
        acc(1'b1, BPS_CMD_OFF, 4'hF, 32'h4000_0000);
        check("serr clear", {oe_n, st}, {1'b1, 16'h0210});
    endtask
    task automatic t_parity;
        pin_n = 1'b0;
        evt.bus_master = 1'b1;
        step(8);
        check("perr no resp", st[8], 1'b0);
        acc(1'b1, BPS_CMD_OFF, 4'h3, 32'h40);
        step(2);
        check("perr resp", st[8], 1'b1);
        pin_n = 1'b1;
        evt = '0;
        step(6);
        acc(1'b1, BPS_CMD_OFF, 4'hF, 32'h0100_0000);
        check("perr clear", st, 32'h0210);
    endtask
    task automatic t_race;
        fork
            acc(1'b1, BPS_CMD_OFF, 4'hC, 32'h2000_0000);
            begin
                step(1);
                evt.master_abort_rcvd = 1'b1;
                step(1);
                evt = '0;
            end
        join
        check("set beats clear", st[13], 1'b1);
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        i_reset = 1'b1;
        pin_n = 1'b1;
        evt = '0;
        step(5);
        i_reset = 1'b0;
        t_fixed();
        t_flags();
        t_serr();
        t_parity();
        t_race();
        close_out();
    end
endmodule // bridge_primary_status_regs_bench
